/* design/ptc_pkg.sv */
`default_nettype none
package ptc_pkg;
  // Byte offsets on the register bus
  localparam logic [7:0] PTC_OFF_CLKEN   = 8'h00;
  localparam logic [7:0] PTC_OFF_START   = 8'h04;
  localparam logic [7:0] PTC_OFF_MASK    = 8'h08;
  localparam logic [7:0] PTC_OFF_REQ     = 8'h0c;
  localparam logic [7:0] PTC_OFF_PRLO    = 8'h10;
  localparam logic [7:0] PTC_OFF_PRHI    = 8'h14;
  localparam logic [7:0] PTC_OFF_BUFMODE = 8'h18;
  localparam logic [7:0] PTC_OFF_COMB    = 8'h1c;
  localparam logic [7:0] PTC_OFF_CNT0    = 8'h20;
  localparam logic [7:0] PTC_OFF_CNT1    = 8'h24;
  localparam logic [7:0] PTC_OFF_A0      = 8'h28;
  localparam logic [7:0] PTC_OFF_B0      = 8'h2c;
  localparam logic [7:0] PTC_OFF_C0      = 8'h30;
  localparam logic [7:0] PTC_OFF_D0      = 8'h34;
  localparam logic [7:0] PTC_OFF_A1      = 8'h38;
  localparam logic [7:0] PTC_OFF_B1      = 8'h3c;
  localparam logic [7:0] PTC_OFF_C1      = 8'h40;
  localparam logic [7:0] PTC_OFF_D1      = 8'h44;
  // Bit positions
  localparam int PTC_BIT_CLKEN   = 4;
  localparam int PTC_BIT_START0  = 0;
  localparam int PTC_BIT_START1  = 1;
  localparam int PTC_BIT_CH0_COUNT_CONTINUE_SELECT   = 2;
  localparam int PTC_BIT_CH1_COUNT_CONTINUE_SELECT   = 3;
  localparam int PTC_BIT_CH0     = 1;
  localparam int PTC_BIT_CH1     = 2;
  localparam int PTC_BIT_CH0_C_REGISTER_FUNCTION    = 4;
  localparam int PTC_BIT_CH0_D_REGISTER_FUNCTION    = 5;
  localparam int PTC_BIT_CH1_C_REGISTER_FUNCTION    = 6;
  localparam int PTC_BIT_CH1_D_REGISTER_FUNCTION    = 7;
  // Reset values
  localparam logic [7:0]  PTC_RST_BYTE = 8'h00;
  localparam logic [7:0]  PTC_RST_MASK = 8'h06;
  localparam logic [15:0] PTC_RST_WORD = 16'hffff;
  localparam logic [15:0] PTC_RST_CNT  = 16'h0000;
  // Combination mode select codes, and the bus NONSEQ transfer type
  localparam logic [1:0] PTC_CMD_UNDERFLOW = 2'b10;
  localparam logic [1:0] PTC_CMD_MATCH     = 2'b11;
  localparam logic [1:0] PTC_HTRANS_NONSEQ = 2'b10;
endpackage : ptc_pkg
`default_nettype wire

/* design/ptc_channel.sv */
`default_nettype none
// One counter: counts up, or down when down is set, and flags a compare match
module ptc_channel
  import ptc_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Control
  input  wire logic         clr,
  input  wire logic         run,
  input  wire logic         cont,
  input  wire logic         down,
  input  wire logic         ld,
  input  wire logic [W-1:0] ld_val,
  input  wire logic [W-1:0] cmp,
  // Status
  output logic [W-1:0]      cnt,
  output logic              match,
  output logic              uflow,
  output logic              stopped
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         stopped;
  } ptc_ch_s;

  ptc_ch_s s_q;
  ptc_ch_s s_d;

  // Match and underflow seen in the cycle the counter steps
  assign match = run && !s_q.stopped && (s_q.cnt == cmp);
  assign uflow = run && !s_q.stopped && down && (s_q.cnt == '0);
  assign cnt     = s_q.cnt;
  assign stopped = s_q.stopped;

  always_comb begin
    s_d = s_q;
    if (clr) begin
      s_d.cnt     = '0;
      s_d.stopped = 1'b0;
    end else if (ld) begin
      s_d.cnt     = ld_val;
      s_d.stopped = 1'b0;
    end else if (run && !s_q.stopped) begin
      if (match && !cont) begin
        s_d.stopped = 1'b1;                       // Halt on match [RULE_03] [RULE_04]
      end else if (down) begin
        s_d.cnt = s_q.cnt - W'(1);
      end else begin
        s_d.cnt = match ? '0 : s_q.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : ptc_channel
`default_nettype wire

/* design/ptc_top.sv */
`default_nettype none
// Behaviour
// RULE_01: Clock supply off stops counting, ignores writes, holds timer in reset.
// RULE_02: Clock supply on lets timer run and its registers be read and written.
// RULE_03: Counter 0 stops on match with A0 unless continue select is set.
// RULE_04: Counter 1 stops on match with A1 unless continue select is set.
// RULE_05: Each counter runs while its start flag is 1, stops while 0.
// RULE_06: Mask bit 0 allows interrupt servicing, 1 blocks it, per channel.
// RULE_07: Request flag sets on interrupt event, reads 0 when nothing pending.
// RULE_08: Software clears request flags and masks both before starting the timer.
// RULE_09: Two priority bits give level 0 highest through level 3 lowest.
// RULE_10: D1 buffers B1 when its function bit is 1, else general register.
// RULE_11: C1 buffers A1 when its function bit is 1, else general register.
// RULE_12: D0 buffers B0 when its function bit is 1, else general register.
// RULE_13: C0 buffers A0 when its bit is 1; software keeps it 0 here.
// RULE_14: Handler counts interrupts and reloads buffers on every tenth one.
// RULE_15: Buffers transfer on counter 1 underflow or counter 0 A0 match.
// RULE_16: Software keeps synchronous-operation off in complementary mode.
// RULE_17: Counters advance only with supply on and start flag set.
module ptc_top
  import ptc_pkg::*;
#(
  parameter int W = 16
) (
  // AHB-Lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Interrupt requests to the controller, unmasked and flagged
  output logic             ch0_timer_interrupt,
  output logic             ch1_timer_interrupt,
  output logic [1:0]       ch0_priority_level,
  output logic [1:0]       ch1_priority_level
);
  typedef struct packed {
    logic         wr_pend;
    logic [7:0]   wr_addr;
    logic [31:0]  rdata;
    logic [7:0]   clken;
    logic [7:0]   start;
    logic [7:0]   mask;
    logic [7:0]   req;
    logic [7:0]   prlo;
    logic [7:0]   prhi;
    logic [7:0]   bufmode;
    logic [1:0]   comb;
    logic [W-1:0] a0;
    logic [W-1:0] b0;
    logic [W-1:0] c0;
    logic [W-1:0] d0;
    logic [W-1:0] a1;
    logic [W-1:0] b1;
    logic [W-1:0] c1;
    logic [W-1:0] d1;
  } ptc_top_s;

  ptc_top_s s_q;
  ptc_top_s s_d;

  logic         supply_on;
  logic         tmr_clr;
  logic         run0;
  logic         run1;
  logic [W-1:0] cnt0;
  logic [W-1:0] cnt1;
  logic         match0;
  logic         match1;
  logic         uflow1;
  logic         xfer;
  logic         addr_phase;

  // Supply enable gates the unit except its own register and the bus; off acts as a timer-wide reset
  assign supply_on = s_q.clken[PTC_BIT_CLKEN];          // [RULE_02]
  assign tmr_clr   = !supply_on;                        // [RULE_01]
  assign run0 = supply_on && s_q.start[PTC_BIT_START0]; // [RULE_05] [RULE_17]
  assign run1 = supply_on && s_q.start[PTC_BIT_START1]; // [RULE_05] [RULE_17]

  // Transfer event chosen by combination mode
  assign xfer = (s_q.comb == PTC_CMD_UNDERFLOW) ? uflow1 :
                (s_q.comb == PTC_CMD_MATCH)     ? match0 : 1'b0; // [RULE_15]

  assign addr_phase = hsel && hready && htrans[1];

  // Counter 0 counts up to A0; counter 1 counts down, reloading from A1 on underflow
  ptc_channel #(.W(W)) u_ch0 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clr     (tmr_clr),
    .run     (run0),
    .cont    (s_q.start[PTC_BIT_CH0_COUNT_CONTINUE_SELECT]),
    .down    (1'b0),
    .ld      (1'b0),
    .ld_val  ('0),
    .cmp     (s_q.a0),
    .cnt     (cnt0),
    .match   (match0),
    .uflow   (),
    .stopped ()
  );

  ptc_channel #(.W(W)) u_ch1 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clr     (tmr_clr),
    .run     (run1),
    .cont    (s_q.start[PTC_BIT_CH1_COUNT_CONTINUE_SELECT]),
    .down    (1'b1),
    .ld      (uflow1),
    .ld_val  (s_q.a1),
    .cmp     (s_q.a1),
    .cnt     (cnt1),
    .match   (match1),
    .uflow   (uflow1),
    .stopped ()
  );

  // Narrow byte register write helper
  function automatic logic [7:0] wbyte(input logic [31:0] d);
    wbyte = d[7:0];
  endfunction : wbyte

  // Read mux; timer registers read their reset values while the supply is off
  function automatic logic [31:0] rd_mux(input ptc_top_s s, input logic [7:0] a,
                                         input logic [W-1:0] c0v, input logic [W-1:0] c1v);
    rd_mux = '0;
    unique case (a)
      PTC_OFF_CLKEN:   rd_mux = {24'h000000, s.clken};
      PTC_OFF_START:   rd_mux = {24'h000000, s.start};
      PTC_OFF_MASK:    rd_mux = {24'h000000, s.mask};
      PTC_OFF_REQ:     rd_mux = {24'h000000, s.req};
      PTC_OFF_PRLO:    rd_mux = {24'h000000, s.prlo};
      PTC_OFF_PRHI:    rd_mux = {24'h000000, s.prhi};
      PTC_OFF_BUFMODE: rd_mux = {24'h000000, s.bufmode};
      PTC_OFF_COMB:    rd_mux = {30'h0, s.comb};
      PTC_OFF_CNT0:    rd_mux = 32'(c0v);
      PTC_OFF_CNT1:    rd_mux = 32'(c1v);
      PTC_OFF_A0:      rd_mux = 32'(s.a0);
      PTC_OFF_B0:      rd_mux = 32'(s.b0);
      PTC_OFF_C0:      rd_mux = 32'(s.c0);
      PTC_OFF_D0:      rd_mux = 32'(s.d0);
      PTC_OFF_A1:      rd_mux = 32'(s.a1);
      PTC_OFF_B1:      rd_mux = 32'(s.b1);
      PTC_OFF_C1:      rd_mux = 32'(s.c1);
      PTC_OFF_D1:      rd_mux = 32'(s.d1);
      default:         rd_mux = '0;
    endcase
  endfunction : rd_mux

  // Next-state logic: bus writes, events, buffer transfers
  always_comb begin
    s_d = s_q;
    s_d.wr_pend = 1'b0;
    // Address phase: latch write, prepare read data for the data phase
    if (addr_phase) begin
      s_d.wr_pend = hwrite;
      s_d.wr_addr = haddr;
      s_d.rdata   = rd_mux(s_q, haddr, cnt0, cnt1);
    end
    // Data phase write; supply register always writable, the rest only when on
    if (s_q.wr_pend) begin
      if (s_q.wr_addr == PTC_OFF_CLKEN) begin
        s_d.clken = wbyte(hwdata);
      end else if (supply_on) begin                     // [RULE_01] [RULE_17]
        unique case (s_q.wr_addr)
          PTC_OFF_START:   s_d.start   = wbyte(hwdata) & 8'h0f;
          PTC_OFF_MASK:    s_d.mask    = wbyte(hwdata);
          PTC_OFF_REQ:     s_d.req     = wbyte(hwdata);
          PTC_OFF_PRLO:    s_d.prlo    = wbyte(hwdata);
          PTC_OFF_PRHI:    s_d.prhi    = wbyte(hwdata);
          PTC_OFF_BUFMODE: s_d.bufmode = wbyte(hwdata) & 8'hf0;
          PTC_OFF_COMB:    s_d.comb    = hwdata[1:0];
          PTC_OFF_A0:      s_d.a0      = hwdata[W-1:0];
          PTC_OFF_B0:      s_d.b0      = hwdata[W-1:0];
          PTC_OFF_C0:      s_d.c0      = hwdata[W-1:0];
          PTC_OFF_D0:      s_d.d0      = hwdata[W-1:0];
          PTC_OFF_A1:      s_d.a1      = hwdata[W-1:0];
          PTC_OFF_B1:      s_d.b1      = hwdata[W-1:0];
          PTC_OFF_C1:      s_d.c1      = hwdata[W-1:0];
          PTC_OFF_D1:      s_d.d1      = hwdata[W-1:0];
          default: ;
        endcase
      end
    end
    // Buffer transfers override a same-cycle general register write
    if (xfer) begin
      if (s_q.bufmode[PTC_BIT_CH0_C_REGISTER_FUNCTION]) s_d.a0 = s_q.c0;   // [RULE_13]
      if (s_q.bufmode[PTC_BIT_CH0_D_REGISTER_FUNCTION]) s_d.b0 = s_q.d0;   // [RULE_12]
      if (s_q.bufmode[PTC_BIT_CH1_C_REGISTER_FUNCTION]) s_d.a1 = s_q.c1;   // [RULE_11]
      if (s_q.bufmode[PTC_BIT_CH1_D_REGISTER_FUNCTION]) s_d.b1 = s_q.d1;   // [RULE_10]
    end
    // Events set flags after any software clear, so a set wins
    if (match0) s_d.req[PTC_BIT_CH0] = 1'b1;            // [RULE_07]
    if (match1) s_d.req[PTC_BIT_CH1] = 1'b1;            // [RULE_07]
    // Timer-side state held in reset while supply is off
    if (tmr_clr) begin                                  // [RULE_01]
      s_d.start   = PTC_RST_BYTE;
      s_d.mask    = PTC_RST_MASK;
      s_d.req     = PTC_RST_BYTE;
      s_d.prlo    = PTC_RST_BYTE;
      s_d.prhi    = PTC_RST_BYTE;
      s_d.bufmode = PTC_RST_BYTE;
      s_d.comb    = 2'b00;
      s_d.a0      = PTC_RST_WORD;
      s_d.b0      = PTC_RST_WORD;
      s_d.c0      = PTC_RST_WORD;
      s_d.d0      = PTC_RST_WORD;
      s_d.a1      = PTC_RST_WORD;
      s_d.b1      = PTC_RST_WORD;
      s_d.c1      = PTC_RST_WORD;
      s_d.d1      = PTC_RST_WORD;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q         <= '0;
      s_q.mask    <= PTC_RST_MASK;
      s_q.a0      <= PTC_RST_WORD;
      s_q.b0      <= PTC_RST_WORD;
      s_q.c0      <= PTC_RST_WORD;
      s_q.d0      <= PTC_RST_WORD;
      s_q.a1      <= PTC_RST_WORD;
      s_q.b1      <= PTC_RST_WORD;
      s_q.c1      <= PTC_RST_WORD;
      s_q.d1      <= PTC_RST_WORD;
    end else begin
      s_q <= s_d;
    end
  end

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_q.rdata;

  // Request reaches the controller only when flagged and unmasked
  assign ch0_timer_interrupt = s_q.req[PTC_BIT_CH0] && !s_q.mask[PTC_BIT_CH0]; // [RULE_06]
  assign ch1_timer_interrupt = s_q.req[PTC_BIT_CH1] && !s_q.mask[PTC_BIT_CH1]; // [RULE_06]
  // Level 0 highest, 3 lowest
  assign ch0_priority_level = {s_q.prhi[PTC_BIT_CH0], s_q.prlo[PTC_BIT_CH0]};  // [RULE_09]
  assign ch1_priority_level = {s_q.prhi[PTC_BIT_CH1], s_q.prlo[PTC_BIT_CH1]};  // [RULE_09]
endmodule : ptc_top
`default_nettype wire

/* test/ptc_asserts.sv */
`default_nettype none
// Watches bus and interrupt pins of the timer control block
module ptc_asserts
  import ptc_pkg::*;
(
  // Bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Interrupt side
  input wire logic        ch0_timer_interrupt,
  input wire logic        ch1_timer_interrupt,
  input wire logic [1:0]  ch0_priority_level,
  input wire logic [1:0]  ch1_priority_level
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       take;
  logic       wr_q;
  logic       on_q;
  logic [7:0] a_q;
  assign take = hsel & hready & htrans[1];
  // Shadow of the supply bit, so only writes that land are judged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      a_q  <= 8'h00;
      on_q <= 1'b0;
    end else begin
      wr_q <= take & hwrite;
      a_q  <= haddr;
      if (wr_q && a_q == PTC_OFF_CLKEN) on_q <= hwdata[PTC_BIT_CLKEN];
    end
  end
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_rdata_hold: assert property (!$past(take) |-> $stable(hrdata))
    else $error("read data moved without a transfer");
  a_unmapped_zero: assert property (take && !hwrite && haddr >= 8'h48 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_mask0_blocks: assert property (wr_q && on_q && a_q == PTC_OFF_MASK && hwdata[PTC_BIT_CH0]
    |=> !ch0_timer_interrupt) else $error("masked channel 0 request passed");
  a_mask1_blocks: assert property (wr_q && on_q && a_q == PTC_OFF_MASK && hwdata[PTC_BIT_CH1]
    |=> !ch1_timer_interrupt) else $error("masked channel 1 request passed");
  a_prio_low: assert property (wr_q && on_q && a_q == PTC_OFF_PRLO |=>
    ch0_priority_level[0] == $past(hwdata[PTC_BIT_CH0])
    && ch1_priority_level[0] == $past(hwdata[PTC_BIT_CH1])) else $error("low priority bit wrong");
  a_prio_high: assert property (wr_q && on_q && a_q == PTC_OFF_PRHI |=>
    ch0_priority_level[1] == $past(hwdata[PTC_BIT_CH0])
    && ch1_priority_level[1] == $past(hwdata[PTC_BIT_CH1])) else $error("high priority bit wrong");
  // Turning the supply off clears the priority bits one cycle after that write lands
  a_prio_steady: assert property ($changed(ch0_priority_level) || $changed(ch1_priority_level)
    |-> $past(wr_q) || !$past(on_q)) else $error("priority moved without a write");
  // Main scenarios reached
  c_irq0: cover property (ch0_timer_interrupt);
  c_irq1: cover property (ch1_timer_interrupt);
  c_prio3: cover property (ch0_priority_level == 2'b11);
endmodule : ptc_asserts
`default_nettype wire

/* test/tb.sv */
`default_nettype none
module tb
  import ptc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        irq0;
  logic        irq1;
  logic [1:0]  lvl0;
  logic [1:0]  lvl1;
  int          error_cnt = 0;
  int          checks = 0;
  int          cyc = 0;
  // 200 MHz clock
  always #2.5 hclk = ~hclk;
  // Single slave, so its ready is the bus ready
  ptc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ch0_timer_interrupt(irq0),
    .ch1_timer_interrupt(irq1), .ch0_priority_level(lvl0), .ch1_priority_level(lvl1));
  task automatic wrap_up();
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  // Hang guard, far above the several hundred cycles the run needs
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One single transfer: address phase, then data phase, each held until ready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= PTC_HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk
  // Pins are looked at mid-cycle, where they have settled
  task automatic irqs(input logic e0, input logic e1);
    @(negedge hclk);
    chk({31'h0, irq0}, {31'h0, e0});
    chk({31'h0, irq1}, {31'h0, e1});
    @(posedge hclk);
  endtask : irqs
  task automatic idle();
    repeat (20) @(posedge hclk);
  endtask : idle
  task automatic t_off();
    rchk(PTC_OFF_A0, {16'h0, PTC_RST_WORD});
    wr(PTC_OFF_A0, 32'h1234);
    wr(PTC_OFF_START, 32'h3);
    idle();
    rchk(PTC_OFF_A0, {16'h0, PTC_RST_WORD});
    rchk(PTC_OFF_CNT1, 32'h0);
  endtask : t_off
  task automatic t_on();
    wr(PTC_OFF_CLKEN, 32'h10);
    rchk(PTC_OFF_CLKEN, 32'h10);
    wr(PTC_OFF_REQ, 32'h0);
    wr(PTC_OFF_MASK, 32'h6);
    rchk(PTC_OFF_MASK, {24'h0, PTC_RST_MASK});
    wr(PTC_OFF_A0, 32'h5);
    rchk(PTC_OFF_A0, 32'h5);
    wr(8'h80, 32'hff);
    rchk(8'h80, 32'h0);
    idle();
    rchk(PTC_OFF_CNT0, 32'h0);
  endtask : t_on
  task automatic t_prio();
    logic [1:0] k;
    for (int c = 0; c < 4; c++) begin
      k = 2'(c);
      wr(PTC_OFF_PRLO, {29'h0, ~k[0], k[0], 1'b0});
      wr(PTC_OFF_PRHI, {29'h0, ~k[1], k[1], 1'b0});
      @(negedge hclk);
      chk({30'h0, lvl0}, {30'h0, k});
      chk({30'h0, lvl1}, {30'h0, ~k});
      @(posedge hclk);
    end
  endtask : t_prio
  // Channel 0 stops on its match, channel 1 on reload into its match
  task automatic t_irq();
    wr(PTC_OFF_START, 32'h1);
    idle();
    rchk(PTC_OFF_CNT0, 32'h5);
    rchk(PTC_OFF_REQ, 32'h2);
    irqs(1'b0, 1'b0);
    wr(PTC_OFF_MASK, 32'h0);
    irqs(1'b1, 1'b0);
    wr(PTC_OFF_REQ, 32'h0);
    rchk(PTC_OFF_REQ, 32'h0);
    wr(PTC_OFF_A1, 32'h7);
    wr(PTC_OFF_START, 32'h2);
    idle();
    rchk(PTC_OFF_CNT1, 32'h7);
    rchk(PTC_OFF_REQ, 32'h4);
    irqs(1'b0, 1'b1);
    wr(PTC_OFF_MASK, 32'h6);
    irqs(1'b0, 1'b0);
  endtask : t_irq
  task automatic t_buf();
    wr(PTC_OFF_CLKEN, 32'h0);
    wr(PTC_OFF_CLKEN, 32'h10);
    rchk(PTC_OFF_CNT1, 32'h0);
    wr(PTC_OFF_A0, 32'h5);
    wr(PTC_OFF_C0, 32'h21);
    wr(PTC_OFF_D0, 32'h22);
    wr(PTC_OFF_C1, 32'h23);
    wr(PTC_OFF_D1, 32'h24);
    wr(PTC_OFF_COMB, {30'h0, PTC_CMD_MATCH});
    wr(PTC_OFF_BUFMODE, 32'he0);
    wr(PTC_OFF_START, 32'h5);
    idle();
    rchk(PTC_OFF_A0, 32'h5);
    rchk(PTC_OFF_B0, 32'h22);
    rchk(PTC_OFF_A1, 32'h23);
    rchk(PTC_OFF_B1, 32'h24);
    wr(PTC_OFF_START, 32'h0);
    wr(PTC_OFF_COMB, {30'h0, PTC_CMD_UNDERFLOW});
    wr(PTC_OFF_BUFMODE, 32'h0);
    wr(PTC_OFF_D0, 32'h31);
    wr(PTC_OFF_START, 32'ha);
    idle();
    rchk(PTC_OFF_B0, 32'h22);
    wr(PTC_OFF_BUFMODE, 32'h20);
    idle();
    rchk(PTC_OFF_B0, 32'h31);
  endtask : t_buf
  // Handler stand-in: clear each channel 0 request, reload the buffer on the tenth
  task automatic t_tenth();
    wr(PTC_OFF_START, 32'h0);
    wr(PTC_OFF_A0, 32'h20);
    wr(PTC_OFF_COMB, {30'h0, PTC_CMD_MATCH});
    wr(PTC_OFF_D0, 32'h40);
    wr(PTC_OFF_REQ, 32'h0);
    wr(PTC_OFF_MASK, 32'h4);
    wr(PTC_OFF_START, 32'h5);
    for (int n = 1; n <= 10; n++) begin
      // Step past the clear so one request is not counted twice
      @(posedge hclk);
      while (irq0 !== 1'b1) @(posedge hclk);
      wr(PTC_OFF_REQ, 32'h0);
      if (n == 10) wr(PTC_OFF_D0, 32'h41);
    end
    rchk(PTC_OFF_B0, 32'h40);
    @(posedge hclk);
    while (irq0 !== 1'b1) @(posedge hclk);
    rchk(PTC_OFF_B0, 32'h41);
  endtask : t_tenth
  // Main sequence
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_off();
    t_on();
    t_prio();
    t_irq();
    t_buf();
    t_tenth();
    wrap_up();
  end
endmodule : tb
bind ptc_top ptc_asserts u_chk (
  .hclk                (hclk),
  .hresetn             (hresetn),
  .hsel                (hsel),
  .haddr               (haddr),
  .htrans              (htrans),
  .hwrite              (hwrite),
  .hsize               (hsize),
  .hwdata              (hwdata),
  .hready              (hready),
  .hrdata              (hrdata),
  .hreadyout           (hreadyout),
  .hresp               (hresp),
  .ch0_timer_interrupt (ch0_timer_interrupt),
  .ch1_timer_interrupt (ch1_timer_interrupt),
  .ch0_priority_level  (ch0_priority_level),
  .ch1_priority_level  (ch1_priority_level)
);
`default_nettype wire
